// [rtl/laser_dither_thermal_age_regs.sv]
// Dither, temperature warning and laser age register bank.
// Assumes a host command engine on the same clock driving the plain
// register port, and temperature and age words sampled from outside logic.
`timescale 1ns/100ps
// Summary of operation
// - Dither rate is unsigned kHz, shape separate
// - FM deviation unsigned, units of 0.1 GHz
// - AM depth unsigned, ten times percent
// - Control bit 1 turns dither on
// - Control bits 5:4 select sine or triangle
// - Rate between steps snaps to nearest step
// - Thermal warning after 5 s out of limits
// - Temperature limits signed, hundredths of degree
// - Temperature limit writes apply at once
// - Out-of-range age threshold write gives range error
// - Age above fatal threshold sets fatal flag
// - Age above warning threshold sets warning flag
// - Age thresholds hold percent 0 to 100
// - Laser age register is read only percent
// - Age threshold write applies; value echoed only by readback
// - Failed read returns error and zero data
// - Dither setting writes refused while dither on
module laser_dither_thermal_age_regs #(
  parameter longint unsigned PERSIST_CNT = laser_regs_pkg::PERSIST_CYCLES
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_b,
  input  wire logic [7:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic [15:0] i_base_temp,
  input  wire logic [15:0] i_wearout,
  output logic      [15:0] o_rdata,
  output logic             o_exec_error,
  output logic      [3:0]  o_error_code,
  output logic             o_modulation_on,
  output logic      [1:0]  o_waveform_select,
  output logic      [15:0] o_rate_applied_khz,
  output logic      [15:0] o_fm_deviation,
  output logic      [15:0] o_am_depth,
  output logic             o_thermal_warning_flag,
  output logic             o_fatal_aging_flag,
  output logic             o_warning_aging_flag
);
  import laser_regs_pkg::*;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [15:0] temp_s1_q;
  logic [15:0] temp_s2_q;
  logic [15:0] age_s1_q;
  logic [15:0] age_s2_q;

  // Multi-bit words assumed slow moving; a stray mixed sample lasts one cycle
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      temp_s1_q <= RST_ZERO;
      temp_s2_q <= RST_ZERO;
      age_s1_q  <= RST_ZERO;
      age_s2_q  <= RST_ZERO;
    end else begin
      temp_s1_q <= i_base_temp;
      temp_s2_q <= temp_s1_q;
      age_s1_q  <= i_wearout;
      age_s2_q  <= age_s1_q;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [15:0] dither_control_q;
  logic [15:0] dither_rate_khz_q;
  logic [15:0] fm_deviation_setting_q;
  logic [15:0] am_depth_setting_q;
  logic [15:0] low_temp_warning_limit_q;
  logic [15:0] high_temp_warning_limit_q;
  logic [15:0] fatal_aging_threshold_q;
  logic [15:0] warning_aging_threshold_q;
  logic        dither_on;
  logic        wr_dither_ctl;
  logic        wr_rate;
  logic        wr_fm;
  logic        wr_am;
  logic        wr_low;
  logic        wr_high;
  logic        wr_fatal;
  logic        wr_warn;
  logic        age_range_bad;
  logic        dither_val_bad;
  logic        wr_known;

  assign dither_on      = dither_control_q[BIT_MODULATION_ON];
  assign age_range_bad  = (i_wdata > AGE_MAX);
  assign dither_val_bad = ((i_addr == ADDR_DITHER_RATE_KHZ)
                           && ((i_wdata < RATE_MIN_KHZ) || (i_wdata > RATE_MAX_KHZ)))
                        || ((i_addr == ADDR_FM_DEVIATION) && (i_wdata > FM_MAX))
                        || ((i_addr == ADDR_AM_DEPTH) && (i_wdata > AM_MAX));
  assign wr_dither_ctl  = i_wr && (i_addr == ADDR_DITHER_CONTROL)
                        && (i_wdata[WF_MSB:WF_LSB] <= WF_TRIANGLE);
  assign wr_rate  = i_wr && (i_addr == ADDR_DITHER_RATE_KHZ) && !dither_on && !dither_val_bad;
  assign wr_fm    = i_wr && (i_addr == ADDR_FM_DEVIATION) && !dither_on && !dither_val_bad;
  assign wr_am    = i_wr && (i_addr == ADDR_AM_DEPTH) && !dither_on && !dither_val_bad;
  assign wr_low   = i_wr && (i_addr == ADDR_LOW_TEMP_LIMIT);
  assign wr_high  = i_wr && (i_addr == ADDR_HIGH_TEMP_LIMIT);
  assign wr_fatal = i_wr && (i_addr == ADDR_FATAL_AGING_TH) && !age_range_bad;
  assign wr_warn  = i_wr && (i_addr == ADDR_WARNING_AGING_TH) && !age_range_bad;
  assign wr_known = (i_addr >= ADDR_DITHER_CONTROL) && (i_addr <= ADDR_WARNING_AGING_TH);

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      dither_control_q <= RST_DITHER_CONTROL;
    end else if (wr_dither_ctl) begin
      dither_control_q <= i_wdata;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      dither_rate_khz_q      <= RST_DITHER_RATE;
      fm_deviation_setting_q <= RST_ZERO;
      am_depth_setting_q     <= RST_ZERO;
    end else begin
      if (wr_rate) begin
        dither_rate_khz_q <= i_wdata;
      end
      if (wr_fm) begin
        fm_deviation_setting_q <= i_wdata;
      end
      if (wr_am) begin
        am_depth_setting_q <= i_wdata;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      low_temp_warning_limit_q  <= RST_LOW_TEMP;
      high_temp_warning_limit_q <= RST_HIGH_TEMP;
    end else begin
      if (wr_low) begin
        low_temp_warning_limit_q <= i_wdata;
      end
      if (wr_high) begin
        high_temp_warning_limit_q <= i_wdata;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      fatal_aging_threshold_q   <= RST_FATAL_TH;
      warning_aging_threshold_q <= RST_WARNING_TH;
    end else begin
      if (wr_fatal) begin
        fatal_aging_threshold_q <= i_wdata;
      end
      if (wr_warn) begin
        warning_aging_threshold_q <= i_wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // Applied dither settings
  // ---------------------------------------------------------------
  logic [15:0] rate_rem;
  logic [15:0] rate_down;
  logic [15:0] rate_near;

  // Supported rates are whole steps; round half up to the nearest one
  assign rate_rem  = dither_rate_khz_q % RATE_STEP_KHZ;
  assign rate_down = dither_rate_khz_q - rate_rem;
  assign rate_near = ((rate_rem << 1) >= RATE_STEP_KHZ)
                   ? 16'(rate_down + RATE_STEP_KHZ) : rate_down;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_modulation_on    <= 1'b0;
      o_waveform_select  <= WF_SINE;
      o_rate_applied_khz <= RST_DITHER_RATE;
      o_fm_deviation     <= RST_ZERO;
      o_am_depth         <= RST_ZERO;
    end else begin
      o_modulation_on    <= dither_on;
      o_waveform_select  <= dither_control_q[WF_MSB:WF_LSB];
      o_rate_applied_khz <= rate_near;
      o_fm_deviation     <= fm_deviation_setting_q;
      o_am_depth         <= am_depth_setting_q;
    end
  end

  // ---------------------------------------------------------------
  // Thermal persistence
  // ---------------------------------------------------------------
  logic [39:0] persist_q;
  logic        out_of_limits;

  assign out_of_limits = ($signed(temp_s2_q) > $signed(high_temp_warning_limit_q))
                       || ($signed(temp_s2_q) < $signed(low_temp_warning_limit_q));

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      persist_q <= 40'h0;
    end else if (!out_of_limits) begin
      persist_q <= 40'h0;
    end else if (persist_q < 40'(PERSIST_CNT)) begin
      persist_q <= persist_q + 40'h1;
    end
  end

  // Flag is a live condition; it drops as soon as the count restarts
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_thermal_warning_flag <= 1'b0;
    end else begin
      o_thermal_warning_flag <= out_of_limits && (persist_q >= 40'(PERSIST_CNT));
    end
  end

  // ---------------------------------------------------------------
  // Aging comparison
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_fatal_aging_flag   <= 1'b0;
      o_warning_aging_flag <= 1'b0;
    end else begin
      o_fatal_aging_flag   <= (age_s2_q > fatal_aging_threshold_q);
      o_warning_aging_flag <= (age_s2_q > warning_aging_threshold_q);
    end
  end

  // ---------------------------------------------------------------
  // Read path and access status
  // ---------------------------------------------------------------
  logic [15:0] rd_d;
  logic        rd_hit;

  always_comb begin
    rd_d   = RST_ZERO;
    rd_hit = 1'b1;
    unique case (i_addr)
      ADDR_DITHER_CONTROL:   rd_d = dither_control_q;
      ADDR_DITHER_RATE_KHZ:  rd_d = dither_rate_khz_q;
      ADDR_FM_DEVIATION:     rd_d = fm_deviation_setting_q;
      ADDR_AM_DEPTH:         rd_d = am_depth_setting_q;
      ADDR_LOW_TEMP_LIMIT:   rd_d = low_temp_warning_limit_q;
      ADDR_HIGH_TEMP_LIMIT:  rd_d = high_temp_warning_limit_q;
      ADDR_FATAL_AGING_TH:   rd_d = fatal_aging_threshold_q;
      ADDR_WARNING_AGING_TH: rd_d = warning_aging_threshold_q;
      ADDR_LASER_WEAROUT:    rd_d = age_s2_q;
      ADDR_FATAL_STATUS:     rd_d = 16'({o_fatal_aging_flag, 1'b0});
      ADDR_WARNING_STATUS:   rd_d = 16'({o_warning_aging_flag, o_thermal_warning_flag});
      ADDR_ACCESS_STATUS:    rd_d = 16'({o_exec_error, o_error_code});
      default:               rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_rdata <= RST_ZERO;
    end else if (i_rd && rd_hit) begin
      o_rdata <= rd_d;
    end else begin
      o_rdata <= RST_ZERO;
    end
  end

  // Status describes the last access; write data echo is via readback
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_exec_error <= 1'b0;
      o_error_code <= ERR_OK;
    end else if (i_rd) begin
      o_exec_error <= !rd_hit;
      o_error_code <= rd_hit ? ERR_OK : ERR_BAD_REGISTER;
    end else if (i_wr) begin
      if (!wr_known) begin
        o_exec_error <= 1'b1;
        o_error_code <= ERR_BAD_REGISTER;
      end else if (((i_addr == ADDR_FATAL_AGING_TH) || (i_addr == ADDR_WARNING_AGING_TH))
                   && age_range_bad) begin
        o_exec_error <= 1'b1;
        o_error_code <= ERR_RANGE_VALUE;
      end else if ((i_addr >= ADDR_DITHER_RATE_KHZ) && (i_addr <= ADDR_AM_DEPTH)
                   && (dither_on || dither_val_bad)) begin
        o_exec_error <= 1'b1;
        o_error_code <= ERR_EXEC_FAILED;
      end else if ((i_addr == ADDR_DITHER_CONTROL) && !wr_dither_ctl) begin
        o_exec_error <= 1'b1;
        o_error_code <= ERR_EXEC_FAILED;
      end else begin
        o_exec_error <= 1'b0;
        o_error_code <= ERR_OK;
      end
    end
  end
endmodule : laser_dither_thermal_age_regs

// [pkg/laser_regs_pkg.sv]
// Register map, fields, reset values and timing of the laser register bank.
// Assumes a 100 MHz system clock and 8-bit register numbers.
package laser_regs_pkg;
  // ---------------------------------------------------------------
  // Register numbers
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_DITHER_CONTROL    = 8'h59;
  localparam logic [7:0] ADDR_DITHER_RATE_KHZ   = 8'h5a;
  localparam logic [7:0] ADDR_FM_DEVIATION      = 8'h5b;
  localparam logic [7:0] ADDR_AM_DEPTH          = 8'h5c;
  localparam logic [7:0] ADDR_LOW_TEMP_LIMIT    = 8'h5d;
  localparam logic [7:0] ADDR_HIGH_TEMP_LIMIT   = 8'h5e;
  localparam logic [7:0] ADDR_FATAL_AGING_TH    = 8'h5f;
  localparam logic [7:0] ADDR_WARNING_AGING_TH  = 8'h60;
  localparam logic [7:0] ADDR_LASER_WEAROUT     = 8'h61;
  localparam logic [7:0] ADDR_FATAL_STATUS      = 8'h20;
  localparam logic [7:0] ADDR_WARNING_STATUS    = 8'h21;
  localparam logic [7:0] ADDR_ACCESS_STATUS     = 8'h70;
  // ---------------------------------------------------------------
  // Fields
  // ---------------------------------------------------------------
  localparam int unsigned BIT_MODULATION_ON     = 1;
  localparam int unsigned WF_LSB                = 4;
  localparam int unsigned WF_MSB                = 5;
  localparam logic [1:0]  WF_SINE               = 2'h0;
  localparam logic [1:0]  WF_TRIANGLE           = 2'h1;
  localparam int unsigned BIT_THERMAL_WARN      = 0;
  localparam int unsigned BIT_WARN_AGING        = 1;
  localparam int unsigned BIT_FATAL_AGING       = 1;
  // ---------------------------------------------------------------
  // Error codes in the access status field
  // ---------------------------------------------------------------
  localparam logic [3:0] ERR_OK                 = 4'h0;
  localparam logic [3:0] ERR_RANGE_VALUE        = 4'h1;
  localparam logic [3:0] ERR_EXEC_FAILED        = 4'h2;
  localparam logic [3:0] ERR_BAD_REGISTER       = 4'h3;
  // ---------------------------------------------------------------
  // Reset values and limits
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_LOW_TEMP          = 16'hfe0c;
  localparam logic [15:0] RST_HIGH_TEMP         = 16'h1b58;
  localparam logic [15:0] RST_FATAL_TH          = 16'h0064;
  localparam logic [15:0] RST_WARNING_TH        = 16'h0050;
  localparam logic [15:0] RST_DITHER_CONTROL    = 16'h0000;
  localparam logic [15:0] RST_DITHER_RATE       = 16'h0064;
  localparam logic [15:0] RST_ZERO              = 16'h0000;
  localparam logic [15:0] AGE_MAX               = 16'h0064;
  localparam logic [15:0] RATE_MIN_KHZ          = 16'h000a;
  localparam logic [15:0] RATE_MAX_KHZ          = 16'h00c8;
  localparam logic [15:0] RATE_STEP_KHZ         = 16'h0005;
  localparam logic [15:0] FM_MAX                = 16'h0064;
  localparam logic [15:0] AM_MAX                = 16'h0064;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ                = 100_000_000;
  localparam int unsigned PERSIST_S             = 5;
  localparam longint unsigned PERSIST_CYCLES    = longint'(PERSIST_S) * longint'(CLK_HZ);
endpackage : laser_regs_pkg

// [test/laser_regs_sva.sv]
// Port checker for the laser register bank.
// Assumes a bind to the bank; sees only its ports.
`timescale 1ns/100ps
module laser_regs_checker import laser_regs_pkg::*; #(
  parameter longint unsigned PERSIST_CNT = 20
) (
  input wire logic        i_sys_clk,
  input wire logic        i_rst_b,
  input wire logic [7:0]  i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [15:0] i_wearout,
  input wire logic [15:0] o_rdata,
  input wire logic        o_exec_error,
  input wire logic [3:0]  o_error_code,
  input wire logic        o_modulation_on,
  input wire logic [1:0]  o_waveform_select,
  input wire logic [15:0] o_rate_applied_khz,
  input wire logic [15:0] o_fm_deviation,
  input wire logic [15:0] o_am_depth,
  input wire logic        o_thermal_warning_flag
);
  // ------------
  // Helper logic
  // ------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  longint unsigned low_cnt_q;
  logic            th_wr;
  logic            dith_wr;
  logic            ctl_wr;
  assign th_wr   = i_wr && (i_addr == ADDR_FATAL_AGING_TH || i_addr == ADDR_WARNING_AGING_TH);
  assign ctl_wr  = i_wr && (i_addr == ADDR_DITHER_CONTROL);
  assign dith_wr = i_wr && i_addr >= ADDR_DITHER_RATE_KHZ && i_addr <= ADDR_AM_DEPTH;
  // Flag low time; one cycle of slack for the clear path
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b || o_thermal_warning_flag) begin
      low_cnt_q <= 64'h0;
    end else begin
      low_cnt_q <= low_cnt_q + 64'h1;
    end
  end
  // ------------
  // Assertions
  // ------------
  AST_THERM_PERSIST: assert property (
    $rose(o_thermal_warning_flag) |-> low_cnt_q >= PERSIST_CNT - 1) else $error("thermal early");
  AST_AGE_READ: assert property (
    $stable(i_wearout)[*4] ##0 (i_rd && i_addr == ADDR_LASER_WEAROUT)
    |=> o_rdata == $past(i_wearout)) else $error("age read mismatch");
  AST_BAD_READ: assert property (
    i_rd && i_addr < ADDR_FATAL_STATUS |=> o_rdata == RST_ZERO && o_exec_error
    && o_error_code == ERR_BAD_REGISTER) else $error("unmapped read answer");
  AST_TH_RANGE: assert property (
    th_wr && i_wdata > AGE_MAX |=> o_exec_error && o_error_code == ERR_RANGE_VALUE)
    else $error("range error missing");
  AST_TH_OK: assert property (
    th_wr && i_wdata <= AGE_MAX |=> !o_exec_error && o_error_code == ERR_OK)
    else $error("threshold write refused");
  // Enable output lags the control word by a cycle; skip a write right after control
  AST_DITHER_LOCKED: assert property (
    dith_wr && o_modulation_on && !$past(ctl_wr) |=> o_exec_error
    && o_error_code == ERR_EXEC_FAILED
    && $stable(o_fm_deviation) && $stable(o_am_depth) && $stable(o_rate_applied_khz))
    else $error("dither change accepted while on");
  AST_CONTROL: assert property (
    (ctl_wr && i_wdata[WF_MSB:WF_LSB] <= WF_TRIANGLE) ##1 !ctl_wr
    |=> o_modulation_on == $past(i_wdata[BIT_MODULATION_ON], 2)
    && o_waveform_select == $past(i_wdata[WF_MSB:WF_LSB], 2))
    else $error("control fields wrong");
  AST_BAD_WAVE: assert property (
    ctl_wr && i_wdata[WF_MSB:WF_LSB] > WF_TRIANGLE
    |=> o_error_code == ERR_EXEC_FAILED && $stable(o_waveform_select))
    else $error("bad waveform stored");
  AST_LIMIT_OK: assert property (
    i_wr && (i_addr == ADDR_LOW_TEMP_LIMIT || i_addr == ADDR_HIGH_TEMP_LIMIT)
    |=> !o_exec_error) else $error("limit write refused");
  AST_RATE_SNAP: assert property (
    i_wr && i_addr == ADDR_DITHER_RATE_KHZ && !o_modulation_on && !$past(ctl_wr)
    && i_wdata >= RATE_MIN_KHZ && i_wdata <= RATE_MAX_KHZ
    |-> ##2 o_rate_applied_khz == 16'(($past(i_wdata, 2) + RATE_STEP_KHZ / 16'h0002)
    / RATE_STEP_KHZ * RATE_STEP_KHZ)) else $error("rate not snapped");
endmodule : laser_regs_checker
bind laser_dither_thermal_age_regs laser_regs_checker #(.PERSIST_CNT(PERSIST_CNT)) chk_inst (
  .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .i_wearout(i_wearout), .o_rdata(o_rdata),
  .o_exec_error(o_exec_error), .o_error_code(o_error_code),
  .o_modulation_on(o_modulation_on), .o_waveform_select(o_waveform_select),
  .o_rate_applied_khz(o_rate_applied_khz), .o_fm_deviation(o_fm_deviation),
  .o_am_depth(o_am_depth), .o_thermal_warning_flag(o_thermal_warning_flag));

// [test/laser_host_model.sv]
// Host command engine model on the plain register port.
// Assumes the bank answers one cycle after each strobe.
`timescale 1ns/100ps
module laser_host_model (
  input  wire logic        i_sys_clk,
  input  wire logic [15:0] i_rdata,
  input  wire logic        i_exec_error,
  input  wire logic [3:0]  i_error_code,
  output logic      [7:0]  o_addr,
  output logic      [15:0] o_wdata,
  output logic             o_wr,
  output logic             o_rd
);
  initial begin
    o_addr  = 8'hff;
    o_wdata = 16'hffff;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end
  // Idle bus shows the inverse, so stale values never pass
  task automatic access(input logic w, input logic [7:0] a, input logic [15:0] d,
                        output logic [15:0] q, output logic [3:0] c, output logic e);
    @(posedge i_sys_clk);
    o_wr    <= w;
    o_rd    <= !w;
    o_addr  <= a;
    o_wdata <= d;
    @(posedge i_sys_clk);
    o_wr    <= 1'b0;
    o_rd    <= 1'b0;
    o_addr  <= ~a;
    o_wdata <= ~d;
    #1;
    q = i_rdata;
    c = i_error_code;
    e = i_exec_error;
  endtask : access
endmodule : laser_host_model

// [test/laser_dither_thermal_age_regs_tb.sv]
// Self-checking bench for the laser register bank.
// Assumes a persistence count shortened to 20 cycles.
`timescale 1ns/100ps
module laser_dither_thermal_age_regs_tb;
  import laser_regs_pkg::*;
  typedef struct packed {
    logic w; logic [7:0] a; logic [15:0] d; logic [15:0] q; logic [3:0] c;
  } row_type;
  logic        i_sys_clk = 1'b0, i_rst_b = 1'b0, i_wr, i_rd, xe, o_modulation_on;
  logic        o_thermal_warning_flag, o_fatal_aging_flag, o_warning_aging_flag;
  logic [7:0]  i_addr;
  logic [15:0] i_wdata, i_base_temp = 16'h0100, i_wearout = 16'h0020, o_rdata;
  logic [15:0] o_rate_applied_khz, o_fm_deviation, o_am_depth;
  logic [3:0]  o_error_code;
  logic [1:0]  o_waveform_select;
  int          num_errors = 0, samples_checked = 0, cycles = 0;
  row_type     rows [24] = '{
    '{0, 8'h5d, 16'h0, 16'hfe0c, 0}, '{0, 8'h5e, 16'h0, 16'h1b58, 0},
    '{0, 8'h5f, 16'h0, 16'h0064, 0}, '{0, 8'h60, 16'h0, 16'h0050, 0},
    '{0, 8'h59, 16'h0, 16'h0000, 0}, '{0, 8'h5a, 16'h0, 16'h0064, 0},
    '{0, 8'h61, 16'h0, 16'h0020, 0}, '{1, 8'h5f, 16'h64, 16'h0, 0},
    '{1, 8'h60, 16'h65, 16'h0, 1}, '{0, 8'h60, 16'h0, 16'h0050, 0},
    '{1, 8'h60, 16'h30, 16'h0, 0}, '{0, 8'h60, 16'h0, 16'h0030, 0},
    '{1, 8'h5b, 16'h65, 16'h0, 2}, '{1, 8'h5b, 16'h0a, 16'h0, 0},
    '{0, 8'h5b, 16'h0, 16'h000a, 0}, '{1, 8'h5c, 16'h32, 16'h0, 0},
    '{1, 8'h5a, 16'h0d, 16'h0, 0}, '{0, 8'h00, 16'h0, 16'h0000, 3},
    '{1, 8'h7f, 16'h1234, 16'h0, 3}, '{1, 8'h59, 16'h22, 16'h0, 2},
    '{1, 8'h59, 16'h12, 16'h0, 0}, '{1, 8'h5a, 16'h14, 16'h0, 2},
    '{1, 8'h5d, 16'hff00, 16'h0, 0}, '{0, 8'h5d, 16'h0, 16'hff00, 0}};
  laser_host_model laser_host_model_inst (.i_sys_clk(i_sys_clk), .i_rdata(o_rdata),
    .i_exec_error(xe), .i_error_code(o_error_code), .o_addr(i_addr), .o_wdata(i_wdata),
    .o_wr(i_wr), .o_rd(i_rd));
  laser_dither_thermal_age_regs #(.PERSIST_CNT(20)) laser_dither_thermal_age_regs_inst (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_base_temp(i_base_temp), .i_wearout(i_wearout),
    .o_rdata(o_rdata), .o_exec_error(xe), .o_error_code(o_error_code),
    .o_modulation_on(o_modulation_on), .o_waveform_select(o_waveform_select),
    .o_rate_applied_khz(o_rate_applied_khz), .o_fm_deviation(o_fm_deviation),
    .o_am_depth(o_am_depth), .o_thermal_warning_flag(o_thermal_warning_flag),
    .o_fatal_aging_flag(o_fatal_aging_flag), .o_warning_aging_flag(o_warning_aging_flag));
  // ------------
  // Helpers
  // ------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d,
                     input logic [15:0] q_exp, input logic [3:0] c_exp);
    logic [15:0] q;
    logic [3:0]  c;
    logic        e;
    laser_host_model_inst.access(w, a, d, q, c, e);
    check("rdata", q, q_exp);
    check("code", {12'h000, c}, {12'h000, c_exp});
    check("exec_error", {15'h0000, e}, {15'h0000, c_exp != ERR_OK});
  endtask : acc
  task automatic hold(input logic [15:0] t, input logic [15:0] age, input int n);
    @(posedge i_sys_clk);
    i_base_temp <= t;
    i_wearout   <= age;
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask : hold
  task automatic results();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results
  // ------------
  // Sequence
  // ------------
  initial begin
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  // Ceiling well above the roughly 180 cycles the run needs
  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      results();
    end
  end
  initial begin
    repeat (20) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    foreach (rows[k]) begin
      acc(rows[k].w, rows[k].a, rows[k].d, rows[k].q, rows[k].c);
    end
    check("rate", o_rate_applied_khz, 16'h000f);
    check("fm", o_fm_deviation, 16'h000a);
    check("am", o_am_depth, 16'h0032);
    check("ctrl", {13'h0000, o_waveform_select, o_modulation_on}, 16'h0003);
    hold(16'h0100, 16'h0031, 6);
    check("warn_age", {14'h0000, o_fatal_aging_flag, o_warning_aging_flag}, 16'h0001);
    acc(0, 8'h21, 16'h0, 16'h0002, 0);
    acc(1, 8'h60, 16'h0031, 16'h0, 0);
    // Flag follows a new threshold one cycle after the write
    hold(16'h0100, 16'h0031, 1);
    check("warn_age", {15'h0000, o_warning_aging_flag}, 16'h0000);
    hold(16'h0100, 16'h0065, 6);
    acc(0, 8'h20, 16'h0, 16'h0002, 0);
    hold(16'h1c00, 16'h0065, 10);
    hold(16'h0100, 16'h0065, 4);
    hold(16'h1c00, 16'h0065, 12);
    check("therm", {15'h0000, o_thermal_warning_flag}, 16'h0000);
    hold(16'h1c00, 16'h0065, 15);
    check("therm", {15'h0000, o_thermal_warning_flag}, 16'h0001);
    hold(16'h0100, 16'h0065, 5);
    check("therm", {15'h0000, o_thermal_warning_flag}, 16'h0000);
    hold(16'hfe00, 16'h0065, 30);
    acc(0, 8'h21, 16'h0, 16'h0003, 0);
    // Reset in mid-run restores the power-up state
    @(posedge i_sys_clk);
    i_rst_b <= 1'b0;
    hold(16'h0100, 16'h0020, 3);
    check("rst_flags", {14'h0000, o_thermal_warning_flag, o_fatal_aging_flag}, 16'h0000);
    @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    acc(0, 8'h5d, 16'h0, 16'hfe0c, 0);
    check("rate", o_rate_applied_khz, 16'h0064);
    check("ctrl", {13'h0000, o_waveform_select, o_modulation_on}, 16'h0000);
    acc(0, 8'h59, 16'h0, 16'h0000, 0);
    results();
  end
endmodule : laser_dither_thermal_age_regs_tb
